// ===== hdl/cits_cfg.svh
`ifndef CITS_CFG_SVH
`define CITS_CFG_SVH
// ---------------------------------------------------------------
// Widths of the message object fields
// ---------------------------------------------------------------
`define CITS_CTRL_W      16
`define CITS_WORD_W      16
`define CITS_WORDS       4
`define CITS_MSGNUM_W    6
// ---------------------------------------------------------------
// Flag positions inside the control word
// ---------------------------------------------------------------
`define CITS_FRESH_BIT   15
`define CITS_IRQ_BIT     13
`define CITS_TXREQ_BIT   8
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CITS_CTRL_RST    16'h0000
`define CITS_WORD_RST    16'h0000
`define CITS_NUM_RST     6'h00
`endif

// ===== hdl/cits_pkg.sv
`include "cits_cfg.svh"
// ---------------------------------------------------------------
// Types of the transfer select block
// ---------------------------------------------------------------
package cits_pkg;
	// Direction plus the five select bits, applied as one group
	typedef struct packed {
		logic write_not_read;
		logic control_select;
		logic clear_pending_select;
		logic txreq_or_fresh_select;
		logic low_payload_select;
		logic high_payload_select;
	} cits_select_t;

	// One message object image: control word and payload words
	typedef struct packed {
		logic [`CITS_CTRL_W-1:0]                 ctrl;
		logic [`CITS_WORDS-1:0][`CITS_WORD_W-1:0] payload;
	} cits_obj_t;

	// Transfer sequencer states
	typedef enum logic [1:0] {
		CITS_IDLE  = 2'b00,
		CITS_FETCH = 2'b01,
		CITS_MERGE = 2'b10
	} cits_state_t;
endpackage : cits_pkg

// ===== hdl/cits_xfer_select.sv
`timescale 1ns/1ps
`include "cits_cfg.svh"
module cits_xfer_select (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         sel_wr,
	input  wire cits_pkg::cits_select_t       sel_wdata,
	output      cits_pkg::cits_select_t       sel_q,
	input  wire logic                         ctrl_wr,
	input  wire logic [`CITS_CTRL_W-1:0]      ctrl_wdata,
	input  wire logic [`CITS_WORDS-1:0]       word_wr,
	input  wire logic [`CITS_WORD_W-1:0]      word_wdata,
	output      logic [`CITS_CTRL_W-1:0]      iface_msg_control_reg,
	output      logic [`CITS_WORD_W-1:0]      iface_payload_word0,
	output      logic [`CITS_WORD_W-1:0]      iface_payload_word1,
	output      logic [`CITS_WORD_W-1:0]      iface_payload_word2,
	output      logic [`CITS_WORD_W-1:0]      iface_payload_word3,
	input  wire logic                         cmd_req_wr,
	input  wire logic [`CITS_MSGNUM_W-1:0]    cmd_msg_num,
	output      logic                         busy,
	output      logic                         done,
	output      logic                         ram_rd_en,
	output      logic                         ram_wr_en,
	output      logic [`CITS_MSGNUM_W-1:0]    ram_addr,
	output      cits_pkg::cits_obj_t          ram_wdata,
	input  wire cits_pkg::cits_obj_t          ram_rdata
);
	import cits_pkg::*;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	cits_select_t                        sel_reg;     // Software selects
	cits_select_t                        act_reg;     // Selects of this transfer
	cits_state_t                         state_reg;   // Sequencer state
	cits_state_t                         state_next;  // Next state
	logic [`CITS_MSGNUM_W-1:0]           num_reg;     // Object in work
	logic [`CITS_CTRL_W-1:0]             ctrl_reg;    // Interface control
	logic [`CITS_WORDS-1:0][`CITS_WORD_W-1:0] word_reg; // Interface payload
	logic                                done_reg;    // End of transfer pulse
	cits_obj_t                           merged;      // Object to write back
	logic                                need_write;  // Write back required

	// Payload word index of the low and high halves
	localparam int LOW0  = 0;
	localparam int LOW1  = 1;
	localparam int HIGH0 = 2;
	localparam int HIGH1 = 3;

	// Picks one payload half: new words when selected, else old
	function automatic logic [2*`CITS_WORD_W-1:0] pick_half(
		input logic                      take,
		input logic [2*`CITS_WORD_W-1:0] fresh_words,
		input logic [2*`CITS_WORD_W-1:0] old_words
	);
		pick_half = take ? fresh_words : old_words;
	endfunction : pick_half

	// ---------------------------------------------------------------
	// Select register
	// ---------------------------------------------------------------
	// selects reset to zero
	always_ff @(posedge clk) begin
		if (reset) begin
			sel_reg <= '0;
		end else if (sel_wr) begin
			sel_reg <= sel_wdata;
		end
	end

	// group latched at start
	// Latching keeps a mid-transfer select write from
	// mixing two setups inside one object update.
	always_ff @(posedge clk) begin
		if (reset) begin
			act_reg <= '0;
			num_reg <= `CITS_NUM_RST;
		end else if (state_reg == CITS_IDLE && cmd_req_wr) begin
			act_reg <= sel_reg;
			num_reg <= cmd_msg_num;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Next state: fetch object, then merge and write back
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// Start only from idle; requests while busy are dropped
			CITS_IDLE: begin
				if (cmd_req_wr) begin
					state_next = CITS_FETCH;
				end
			end
			// RAM answers one cycle after the read strobe
			CITS_FETCH: begin
				state_next = CITS_MERGE;
			end
			// Merge and optional write back in one cycle
			CITS_MERGE: begin
				state_next = CITS_IDLE;
			end
			default: begin
				state_next = CITS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= CITS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Done pulse after the merge cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == CITS_MERGE);
		end
	end

	// ---------------------------------------------------------------
	// Merge of the object image
	// ---------------------------------------------------------------
	// Builds the write-back image from the fetched object
	always_comb begin
		merged     = ram_rdata;
		need_write = 1'b0;
		if (act_reg.write_not_read) begin
			need_write = 1'b1;
			if (act_reg.control_select) begin
				merged.ctrl = ctrl_reg;
			end
			if (act_reg.txreq_or_fresh_select) begin
				merged.ctrl[`CITS_TXREQ_BIT] = 1'b1;
			end
			{merged.payload[LOW1], merged.payload[LOW0]} = pick_half(
				act_reg.low_payload_select,
				{word_reg[LOW1], word_reg[LOW0]},
				{ram_rdata.payload[LOW1], ram_rdata.payload[LOW0]});
			{merged.payload[HIGH1], merged.payload[HIGH0]} = pick_half(
				act_reg.high_payload_select,
				{word_reg[HIGH1], word_reg[HIGH0]},
				{ram_rdata.payload[HIGH1], ram_rdata.payload[HIGH0]});
			// clear select has no effect here
		end else begin
			if (act_reg.clear_pending_select) begin
				merged.ctrl[`CITS_IRQ_BIT] = 1'b0;
				need_write                 = 1'b1;
			end
			if (act_reg.txreq_or_fresh_select) begin
				merged.ctrl[`CITS_FRESH_BIT] = 1'b0;
				need_write                   = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Interface buffer registers
	// ---------------------------------------------------------------
	// Control register: software or read transfer
	// Software writes are held off while busy so that the
	// image being merged cannot change under the transfer.
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= `CITS_CTRL_RST;
		end else if (state_reg == CITS_MERGE) begin
			if (!act_reg.write_not_read && act_reg.control_select) begin
				ctrl_reg <= ram_rdata.ctrl;
			end
		end else if (state_reg == CITS_IDLE && ctrl_wr) begin
			ctrl_reg <= ctrl_wdata;
		end
	end

	// Payload registers: software or read transfer
	always_ff @(posedge clk) begin
		if (reset) begin
			word_reg <= {`CITS_WORDS{`CITS_WORD_RST}};
		end else if (state_reg == CITS_MERGE) begin
			if (!act_reg.write_not_read) begin
				if (act_reg.low_payload_select) begin
					word_reg[LOW0] <= ram_rdata.payload[LOW0];
					word_reg[LOW1] <= ram_rdata.payload[LOW1];
				end
				if (act_reg.high_payload_select) begin
					word_reg[HIGH0] <= ram_rdata.payload[HIGH0];
					word_reg[HIGH1] <= ram_rdata.payload[HIGH1];
				end
			end
		end else if (state_reg == CITS_IDLE) begin
			for (int i = 0; i < `CITS_WORDS; i++) begin
				if (word_wr[i]) begin
					word_reg[i] <= word_wdata;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign sel_q                 = sel_reg;
	assign iface_msg_control_reg = ctrl_reg;
	assign iface_payload_word0   = word_reg[LOW0];
	assign iface_payload_word1   = word_reg[LOW1];
	assign iface_payload_word2   = word_reg[HIGH0];
	assign iface_payload_word3   = word_reg[HIGH1];
	assign busy                  = (state_reg != CITS_IDLE);
	assign done                  = done_reg;
	assign ram_addr              = num_reg;
	assign ram_rd_en             = (state_reg == CITS_FETCH);
	assign ram_wr_en             = (state_reg == CITS_MERGE) && need_write;
	assign ram_wdata             = merged;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Merge cycle of a write or of a read
	sequence s_wr_merge;
		state_reg == CITS_MERGE && act_reg.write_not_read;
	endsequence
	sequence s_rd_merge;
		state_reg == CITS_MERGE && !act_reg.write_not_read;
	endsequence
	// Accepted command request
	sequence s_start;
		state_reg == CITS_IDLE && cmd_req_wr;
	endsequence

	property p_ctrl_copy;
		s_wr_merge ##0 act_reg.control_select |->
			ram_wr_en && (((ram_wdata.ctrl ^ ctrl_reg) &
			~(16'h0001 << `CITS_TXREQ_BIT)) == 16'h0000);
	endproperty
	a_ctrl_copy: assert property (p_ctrl_copy)
		else $error("control bits not copied to object");

	property p_ctrl_load;
		s_rd_merge ##0 act_reg.control_select |=>
			iface_msg_control_reg == $past(ram_rdata.ctrl);
	endproperty
	a_ctrl_load: assert property (p_ctrl_load)
		else $error("control register missed pre-clear value");

	property p_pend_clear;
		s_rd_merge ##0 act_reg.clear_pending_select |->
			ram_wr_en && !ram_wdata.ctrl[`CITS_IRQ_BIT];
	endproperty
	a_pend_clear: assert property (p_pend_clear)
		else $error("pending flag not cleared on read");

	property p_pend_write;
		s_wr_merge ##0 !act_reg.control_select |->
			ram_wdata.ctrl[`CITS_IRQ_BIT] == ram_rdata.ctrl[`CITS_IRQ_BIT];
	endproperty
	a_pend_write: assert property (p_pend_write)
		else $error("write transfer changed pending flag");

	property p_txreq_set;
		s_wr_merge ##0 act_reg.txreq_or_fresh_select |->
			ram_wr_en && ram_wdata.ctrl[`CITS_TXREQ_BIT];
	endproperty
	a_txreq_set: assert property (p_txreq_set)
		else $error("transmit request not set");

	property p_fresh_clear;
		s_rd_merge ##0 act_reg.txreq_or_fresh_select |->
			ram_wr_en && !ram_wdata.ctrl[`CITS_FRESH_BIT];
	endproperty
	a_fresh_clear: assert property (p_fresh_clear)
		else $error("fresh flag not cleared on read");

	property p_low_copy;
		s_wr_merge ##0 !act_reg.low_payload_select |->
			ram_wdata.payload[LOW0] == ram_rdata.payload[LOW0];
	endproperty
	a_low_copy: assert property (p_low_copy)
		else $error("unselected low payload changed");

	property p_low_load;
		s_rd_merge ##0 act_reg.low_payload_select |=>
			iface_payload_word1 == $past(ram_rdata.payload[LOW1]);
	endproperty
	a_low_load: assert property (p_low_load)
		else $error("low payload not loaded");

	property p_high_copy;
		s_wr_merge ##0 act_reg.high_payload_select |->
			ram_wdata.payload[HIGH1] == word_reg[HIGH1];
	endproperty
	a_high_copy: assert property (p_high_copy)
		else $error("high payload not copied");

	property p_sequence;
		s_start |=> ram_rd_en ##1 state_reg == CITS_MERGE ##1
			done && !busy;
	endproperty
	a_sequence: assert property (p_sequence)
		else $error("transfer sequence broken");
endmodule : cits_xfer_select

// ===== test/cits_xfer_select_bench.sv
`timescale 1ns/1ps
`include "cits_cfg.svh"
module cits_xfer_select_bench;
	import cits_pkg::*;
	// -----------------------------------------------------------
	// Fixed images and stimulus rows
	// -----------------------------------------------------------
	// Interface: pending set, transmit request clear
	localparam cits_obj_t IFC = {16'h2055, 16'h4444, 16'h3333,
		16'h2222, 16'h1111};
	// Object: fresh and pending set, transmit request clear
	localparam cits_obj_t OBJ = {16'hA0AA, 16'hDDDD, 16'hCCCC,
		16'hBBBB, 16'hAAAA};
	// Row = {selects, expected write back}
	logic [6:0]                rows [16] = '{7'h41, 7'h61, 7'h51,
		7'h49, 7'h69, 7'h45, 7'h43, 7'h7F, 7'h00, 7'h20, 7'h11, 7'h09,
		7'h39, 7'h04, 7'h02, 7'h26};
	logic                      clk         = 1'b0;
	logic                      reset       = 1'b1;
	logic                      sel_wr      = 1'b0;
	cits_select_t              sel_wdata   = 6'h00;
	cits_select_t              sel_q;
	logic                      ctrl_wr     = 1'b0;
	logic [`CITS_CTRL_W-1:0]   ctrl_wdata  = 16'h0000;
	logic [`CITS_WORDS-1:0]    word_wr     = 4'h0;
	logic [`CITS_WORD_W-1:0]   word_wdata  = 16'h0000;
	logic [`CITS_CTRL_W-1:0]   iface_msg_control_reg;
	logic [`CITS_WORD_W-1:0]   iface_payload_word0;
	logic [`CITS_WORD_W-1:0]   iface_payload_word1;
	logic [`CITS_WORD_W-1:0]   iface_payload_word2;
	logic [`CITS_WORD_W-1:0]   iface_payload_word3;
	logic                      cmd_req_wr  = 1'b0;
	logic [`CITS_MSGNUM_W-1:0] cmd_msg_num = 6'h00;
	logic                      busy;
	logic                      done;
	logic                      ram_rd_en;
	logic                      ram_wr_en;
	logic [`CITS_MSGNUM_W-1:0] ram_addr;
	cits_obj_t                 ram_wdata;
	cits_obj_t                 ram_rdata   = ~OBJ;
	int                        err_total   = 0;
	int                        check_count = 0;

	// Free running clock, 25 ns period
	always #12.5 clk = ~clk;

	cits_xfer_select cits_xfer_select_i (
		.clk                   (clk),
		.reset                 (reset),
		.sel_wr                (sel_wr),
		.sel_wdata             (sel_wdata),
		.sel_q                 (sel_q),
		.ctrl_wr               (ctrl_wr),
		.ctrl_wdata            (ctrl_wdata),
		.word_wr               (word_wr),
		.word_wdata            (word_wdata),
		.iface_msg_control_reg (iface_msg_control_reg),
		.iface_payload_word0   (iface_payload_word0),
		.iface_payload_word1   (iface_payload_word1),
		.iface_payload_word2   (iface_payload_word2),
		.iface_payload_word3   (iface_payload_word3),
		.cmd_req_wr            (cmd_req_wr),
		.cmd_msg_num           (cmd_msg_num),
		.busy                  (busy),
		.done                  (done),
		.ram_rd_en             (ram_rd_en),
		.ram_wr_en             (ram_wr_en),
		.ram_addr              (ram_addr),
		.ram_wdata             (ram_wdata),
		.ram_rdata             (ram_rdata)
	);

	// -----------------------------------------------------------
	// Expected images
	// -----------------------------------------------------------
	// Merged object written back to message memory
	function automatic cits_obj_t exp_ram(input cits_select_t s);
		cits_obj_t e;
		e = OBJ;
		if (s.write_not_read) begin
			if (s.control_select) e.ctrl = IFC.ctrl;
			if (s.txreq_or_fresh_select) e.ctrl[`CITS_TXREQ_BIT] = 1'b1;
			if (s.low_payload_select) e.payload[1:0] = IFC.payload[1:0];
			if (s.high_payload_select) e.payload[3:2] = IFC.payload[3:2];
		end else begin
			if (s.clear_pending_select) e.ctrl[`CITS_IRQ_BIT] = 1'b0;
			if (s.txreq_or_fresh_select) e.ctrl[`CITS_FRESH_BIT] = 1'b0;
		end
		return e;
	endfunction : exp_ram

	// Interface image after the transfer
	function automatic cits_obj_t exp_ifc(input cits_select_t s);
		cits_obj_t e;
		e = IFC;
		if (!s.write_not_read) begin
			if (s.control_select) e.ctrl = OBJ.ctrl;
			if (s.low_payload_select) e.payload[1:0] = OBJ.payload[1:0];
			if (s.high_payload_select) e.payload[3:2] = OBJ.payload[3:2];
		end
		return e;
	endfunction : exp_ifc

	function automatic cits_obj_t ifc_now();
		return {iface_msg_control_reg, iface_payload_word3,
			iface_payload_word2, iface_payload_word1, iface_payload_word0};
	endfunction : ifc_now

	// -----------------------------------------------------------
	// Compare and closing tasks
	// -----------------------------------------------------------
	task automatic cmp_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_bit

	task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_word

	task automatic cmp_obj(input cits_obj_t g, input cits_obj_t e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp_obj

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// -----------------------------------------------------------
	// Drivers
	// -----------------------------------------------------------
	// Reset state: everything cleared, nothing moving
	task automatic chk_idle();
		cmp_word({10'h000, sel_q}, 16'h0000);
		cmp_obj(ifc_now(), {80{1'b0}});
		cmp_bit(busy, 1'b0);
		cmp_bit(ram_rd_en | ram_wr_en | done, 1'b0);
		cmp_word({10'h000, ram_addr}, 16'h0000);
	endtask : chk_idle

	// Fill the interface words, then control and selects in one cycle
	task automatic load(input cits_select_t s);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			word_wr    <= 4'h1 << i;
			word_wdata <= IFC.payload[i];
		end
		@(posedge clk);
		word_wr    <= 4'h0;
		ctrl_wr    <= 1'b1;
		ctrl_wdata <= IFC.ctrl;
		sel_wr     <= 1'b1;
		sel_wdata  <= s;
		@(posedge clk);
		ctrl_wr <= 1'b0;
		sel_wr  <= 1'b0;
		#1;
		cmp_obj(ifc_now(), IFC);
		cmp_word({10'h000, sel_q}, {10'h000, s});
	endtask : load

	// One transfer; mid pokes every strobe while busy
	task automatic run_xfer(input cits_select_t s, input logic wen,
		input logic [5:0] num, input logic mid);
		@(posedge clk);
		cmd_req_wr  <= 1'b1;
		cmd_msg_num <= num;
		@(posedge clk);
		cmd_req_wr <= mid;
		ctrl_wr    <= mid;
		ctrl_wdata <= 16'hFFFF;
		word_wr    <= {4{mid}};
		word_wdata <= 16'hFFFF;
		sel_wr     <= mid;
		sel_wdata  <= cits_select_t'(~s);
		#1;
		cmp_bit(busy & ram_rd_en, 1'b1);
		cmp_word({10'h000, ram_addr}, {10'h000, num});
		@(posedge clk);
		{cmd_req_wr, ctrl_wr, sel_wr} <= 3'h0;
		word_wr   <= 4'h0;
		ram_rdata <= OBJ;
		#1;
		cmp_bit(ram_wr_en, wen);
		if (wen) cmp_obj(ram_wdata, exp_ram(s));
		@(posedge clk);
		ram_rdata <= ~OBJ;
		#1;
		cmp_bit(done & ~busy, 1'b1);
		cmp_obj(ifc_now(), exp_ifc(s));
		@(posedge clk);
		#1;
		cmp_bit(ram_rd_en | done, 1'b0);
	endtask : run_xfer

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk_idle();
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			load(rows[i][6:1]);
			run_xfer(rows[i][6:1], rows[i][0], 6'(i), 1'b0);
			$display("test row %0d done", i);
		end
		// Busy strobes dropped; a read with no loads shows it
		load(6'h00);
		run_xfer(6'h00, 1'b0, 6'h3F, 1'b1);
		// Select write itself is taken in any state
		cmp_word({10'h000, sel_q}, 16'h003F);
		$display("test busy strobes done");
		// Second reset in mid run, landing inside a transfer
		load(6'h3F);
		@(posedge clk);
		cmd_req_wr <= 1'b1;
		@(posedge clk);
		cmd_req_wr <= 1'b0;
		reset      <= 1'b1;
		#1;
		cmp_bit(busy, 1'b1);
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk_idle();
		$display("test mid reset done");
		close_out();
	end
endmodule : cits_xfer_select_bench
